/* File: include/pan_pkg.sv */
// Purpose: shared constants for the activity / nmi masking block
// Assumes: word-wide ahb-lite register access, one register per aligned word
// Notes:   byte address of a register is four times its index
package pan_pkg;

   // ----------------------------------------------------------------
   // register indices (byte address = 4 * index)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_SUSPEND_CMD    = 8'hc0;
   localparam logic [7:0] IDX_ACTIVITY_MASK  = 8'hc3;
   localparam logic [7:0] IDX_NMI_SOURCE_MSK = 8'hc4;
   localparam logic [7:0] IDX_IO_WATCH_RANGE = 8'hc5;
   localparam logic [7:0] IDX_NMI_PENDING    = 8'hdc;

   // ----------------------------------------------------------------
   // activity mask fields
   // ----------------------------------------------------------------
   localparam int BIT_CARD_CTRL_ACT = 2;
   localparam int BIT_KEYBOARD_ACT  = 1;
   localparam int BIT_CHIP_SEL_ACT  = 0;
   localparam logic [2:0] ACTIVITY_MASK_RST = 3'h0;

   // ----------------------------------------------------------------
   // nmi source mask fields (pending register uses same positions)
   // ----------------------------------------------------------------
   localparam int BIT_GLOBAL_NMI    = 7;
   localparam int BIT_SUSPEND_TMO   = 5;
   localparam int BIT_SLEEP_NMI     = 4;
   localparam int BIT_BATT_WARN_B   = 3;
   localparam int BIT_BATT_WARN_A   = 2;
   localparam int BIT_OUTSIDE_EVT   = 1;
   localparam logic [7:0] NMI_MASK_RST      = 8'hbe;
   localparam logic [7:0] NMI_MASK_WRITABLE = 8'hbe;
   localparam logic [7:0] NMI_SRC_BITS      = 8'h3e;

   // ----------------------------------------------------------------
   // io watch range fields
   // ----------------------------------------------------------------
   localparam int BIT_WINDOW_SIZE = 7;
   localparam logic [7:0] IO_WATCH_RST = 8'h00;
   localparam logic [15:0] KEYBOARD_IO_ADDR = 16'h0060;

   // ----------------------------------------------------------------
   // ahb-lite encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'b0;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_WAIT = 2'b10
   } pan_bus_state_t;

endpackage

/* File: hdl/pan_activity_nmi.sv */
// Purpose: activity source masking, io watch window and pm nmi masking
// Assumes: ahb-lite register access; all inputs synchronous to CLK
// Notes:   every data phase takes one wait state, so reads see prior writes
//
// Contract
// R1 - card controller accesses count as activity unless mask bit 2 set; resets clear
// R2 - keyboard io 060h counts as activity unless mask bit 1 set; resets clear
// R3 - chip select activity counts as activity unless mask bit 0 set; resets clear
// R4 - global mask bit 7, reset one, blocks nmi but never status setting
// R5 - clearing global mask with any status set raises the nmi; code raises it only when an unmasked source is pending
// R6 - requests pending or arriving while globally masked fire once mask clears
// R7 - outside event resume is unaffected by global and outside nmi masks
// R8 - masked source never makes nmi; pending fires after its mask clears
// R9 - suspend entered only by a command write to index c0h
// R10 - suspend expiry raises nmi when bit 5 clear; never enters suspend
// R11 - bit 4 clear: sleep expiry in doze raises nmi, stays doze
// R12 - bit 4 clear: activity in sleep raises nmi, stays sleep
// R13 - bit 4 set: doze to sleep on expiry, sleep to on on activity
// R14 - battery warn b rising raises nmi when bit 3 clear; reset one
// R15 - battery warn a rising raises nmi when bit 2 clear; reset one
// R16 - outside event rising raises nmi when bit 1 clear; reset one
// R17 - mask bits 6 and 0 reserved, read zero
// R18 - window size bit 7: zero selects 16 bytes, one selects 8
// R19 - window start bits 6..0 compared with address bits 9..3
// R20 - 16 byte window ignores start bit 0, address bit 3 not compared
// R21 - global mask never clears pending sources nor blocks status setting
// R22 - window matches io cycles only, never memory cycles
//
// Design decision made here: register access over AHB-Lite.
module pan_activity_nmi
   import pan_pkg::*;
(
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RESETN,
   // ahb-lite slave
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   // system bus observation
   input  wire logic [15:0] SYSTEM_ADDR_BUS,
   input  wire logic        SYS_IO_CYCLE,
   input  wire logic        SYS_MEM_CYCLE,
   input  wire logic        CARD_CTRL_ACCESS,
   input  wire logic        CHIP_SELECT_ACTIVE,
   // event inputs
   input  wire logic        BATTERY_WARN_A_INPUT,
   input  wire logic        BATTERY_WARN_B_INPUT,
   input  wire logic        OUTSIDE_EVENT_INPUT,
   input  wire logic        SLEEP_TIMER_EXPIRED,
   input  wire logic        SUSPEND_TIMER_EXPIRED,
   // power state from the state machine
   input  wire logic        PM_IN_DOZE,
   input  wire logic        PM_IN_SLEEP,
   // outputs to processor and state machine
   output logic             POWER_MANAGER_NMI,
   output logic             ACTIVITY_DETECTED,
   output logic             RESUME_REQUEST,
   output logic             GO_SLEEP,
   output logic             GO_ON,
   output logic             SUSPEND_COMMAND
);

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   pan_bus_state_t bus_state_q;
   logic [7:0]     addr_idx_q;
   logic           addr_ok_q;
   logic           wr_q;
   logic [2:0]     activity_mask_q;
   logic [7:0]     nmi_mask_q;
   logic [7:0]     io_watch_q;
   logic [7:0]     pending_q;
   logic           batt_a_prev_q;
   logic           batt_b_prev_q;
   logic           outside_prev_q;

   logic           addr_take;
   logic           wr_strobe;
   logic           pend_clr_strobe;
   logic [7:0]     rd_value;
   logic [7:0]     pending_set;
   logic [7:0]     pending_d;
   logic           window_hit;
   logic           keyboard_hit;
   logic           activity_now;
   logic           sleep_mask;
   logic           nmi_request;

   // ----------------------------------------------------------------
   // ahb-lite slave
   // ----------------------------------------------------------------
   assign addr_take = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
   assign wr_strobe = (bus_state_q == BUS_WAIT) && wr_q && addr_ok_q;

   // the wait state lets a read that follows a write see the new value
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         bus_state_q <= BUS_IDLE;
         addr_idx_q  <= 8'h00;
         addr_ok_q   <= 1'b0;
         wr_q        <= 1'b0;
         HREADYOUT   <= 1'b1;
      end else begin
         case (bus_state_q)
            BUS_IDLE: begin
               if (addr_take) begin
                  bus_state_q <= BUS_WAIT;
                  addr_idx_q  <= HADDR[9:2];
                  addr_ok_q   <= (HADDR[31:10] == 22'h000000) && (HADDR[1:0] == 2'h0);
                  wr_q        <= HWRITE;
                  HREADYOUT   <= 1'b0;
               end
            end
            BUS_WAIT: begin
               bus_state_q <= BUS_IDLE;
               HREADYOUT   <= 1'b1;
            end
            default: begin
               bus_state_q <= BUS_IDLE;
               HREADYOUT   <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         HRESP <= HRESP_OKAY;
      end else begin
         HRESP <= HRESP_OKAY;
      end
   end

   // unmapped indices read as zero and ignore writes
   always_comb begin
      rd_value = 8'h00;
      if (!addr_ok_q) begin
         rd_value = 8'h00;
      end else if (addr_idx_q == IDX_ACTIVITY_MASK) begin
         rd_value = {5'h00, activity_mask_q};
      end else if (addr_idx_q == IDX_NMI_SOURCE_MSK) begin
         rd_value = nmi_mask_q;
      end else if (addr_idx_q == IDX_IO_WATCH_RANGE) begin
         rd_value = io_watch_q;
      end else if (addr_idx_q == IDX_NMI_PENDING) begin
         rd_value = pending_q;
      end else begin
         rd_value = 8'h00;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         HRDATA <= 32'h00000000;
      end else if ((bus_state_q == BUS_WAIT) && !wr_q) begin
         HRDATA <= {24'h000000, rd_value};
      end
   end

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   // R1 R2 R3 mask bits, reset clear
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         activity_mask_q <= ACTIVITY_MASK_RST;
      end else if (wr_strobe && (addr_idx_q == IDX_ACTIVITY_MASK)) begin
         activity_mask_q <= HWDATA[2:0];
      end
   end

   // R17 reserved bits 6 and 0 stay zero
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         nmi_mask_q <= NMI_MASK_RST;
      end else if (wr_strobe && (addr_idx_q == IDX_NMI_SOURCE_MSK)) begin
         nmi_mask_q <= HWDATA[7:0] & NMI_MASK_WRITABLE;
      end
   end

   // R18 R19 window register, reset zero
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         io_watch_q <= IO_WATCH_RST;
      end else if (wr_strobe && (addr_idx_q == IDX_IO_WATCH_RANGE)) begin
         io_watch_q <= HWDATA[7:0];
      end
   end

   // R9 suspend only by command write
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         SUSPEND_COMMAND <= 1'b0;
      end else begin
         SUSPEND_COMMAND <= wr_strobe && (addr_idx_q == IDX_SUSPEND_CMD);
      end
   end

   // ----------------------------------------------------------------
   // activity detection
   // ----------------------------------------------------------------
   // R19 R20 R22 window compare on io cycles only
   always_comb begin
      window_hit = 1'b0;
      if (SYS_IO_CYCLE && !SYS_MEM_CYCLE) begin
         if (io_watch_q[BIT_WINDOW_SIZE]) begin
            window_hit = (SYSTEM_ADDR_BUS[9:3] == io_watch_q[6:0]);
         end else begin
            window_hit = (SYSTEM_ADDR_BUS[9:4] == io_watch_q[6:1]);
         end
      end
   end

   // R2 keyboard port decode
   assign keyboard_hit = SYS_IO_CYCLE && !SYS_MEM_CYCLE &&
                         (SYSTEM_ADDR_BUS == KEYBOARD_IO_ADDR);

   // R1 R2 R3 masked activity sources, and the unmasked io window hit
   assign activity_now = (CARD_CTRL_ACCESS && !activity_mask_q[BIT_CARD_CTRL_ACT]) ||
                         (keyboard_hit && !activity_mask_q[BIT_KEYBOARD_ACT]) ||
                         (CHIP_SELECT_ACTIVE && !activity_mask_q[BIT_CHIP_SEL_ACT]) ||
                         window_hit;

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ACTIVITY_DETECTED <= 1'b0;
      end else begin
         ACTIVITY_DETECTED <= activity_now;
      end
   end

   // ----------------------------------------------------------------
   // input edge detection
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         batt_a_prev_q  <= 1'b0;
         batt_b_prev_q  <= 1'b0;
         outside_prev_q <= 1'b0;
      end else begin
         batt_a_prev_q  <= BATTERY_WARN_A_INPUT;
         batt_b_prev_q  <= BATTERY_WARN_B_INPUT;
         outside_prev_q <= OUTSIDE_EVENT_INPUT;
      end
   end

   // R7 resume ignores every nmi mask
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         RESUME_REQUEST <= 1'b0;
      end else begin
         RESUME_REQUEST <= OUTSIDE_EVENT_INPUT && !outside_prev_q;
      end
   end

   // ----------------------------------------------------------------
   // nmi pending and delivery
   // ----------------------------------------------------------------
   assign sleep_mask = nmi_mask_q[BIT_SLEEP_NMI];

   // R21 events latch regardless of global or source masks
   always_comb begin
      pending_set = 8'h00;
      // R10 suspend expiry event
      pending_set[BIT_SUSPEND_TMO] = SUSPEND_TIMER_EXPIRED;
      // R11 R12 sleep expiry in doze, activity in sleep
      pending_set[BIT_SLEEP_NMI]   = (SLEEP_TIMER_EXPIRED && PM_IN_DOZE) ||
                                     (activity_now && PM_IN_SLEEP);
      // R14 R15 R16 rising inputs
      pending_set[BIT_BATT_WARN_B] = BATTERY_WARN_B_INPUT && !batt_b_prev_q;
      pending_set[BIT_BATT_WARN_A] = BATTERY_WARN_A_INPUT && !batt_a_prev_q;
      pending_set[BIT_OUTSIDE_EVT] = OUTSIDE_EVENT_INPUT && !outside_prev_q;
   end

   assign pend_clr_strobe = wr_strobe && (addr_idx_q == IDX_NMI_PENDING);

   // write one to clear; a new event in the same cycle wins
   always_comb begin
      pending_d = pending_q;
      if (pend_clr_strobe) begin
         pending_d = pending_d & ~HWDATA[7:0];
      end
      pending_d = (pending_d | pending_set) & NMI_SRC_BITS;
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         pending_q <= 8'h00;
      end else begin
         pending_q <= pending_d;
      end
   end

   // R4 R5 R6 R8 nmi level follows unmasked pending under global mask
   assign nmi_request = !nmi_mask_q[BIT_GLOBAL_NMI] &&
                        ((pending_q & ~nmi_mask_q & NMI_SRC_BITS) != 8'h00);

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         POWER_MANAGER_NMI <= 1'b0;
      end else begin
         POWER_MANAGER_NMI <= nmi_request;
      end
   end

   // ----------------------------------------------------------------
   // automatic state-change requests
   // ----------------------------------------------------------------
   // R13 automatic moves only with sleep nmi masked; R11 R12 hold state otherwise
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         GO_SLEEP <= 1'b0;
         GO_ON    <= 1'b0;
      end else begin
         GO_SLEEP <= sleep_mask && SLEEP_TIMER_EXPIRED && PM_IN_DOZE;
         GO_ON    <= sleep_mask && activity_now && PM_IN_SLEEP;
      end
   end

endmodule

/* File: testbench/pan_sys_bus_model.sv */
// Purpose: system bus side that makes io, memory, card and chip select cycles
// Assumes: one cycle per access, driven just after a rising edge
// Notes:   idle address shows the inverse of the last one, never a stale copy
module pan_sys_bus_model (
   input  wire logic        clk,
   output logic      [15:0] addr,
   output logic             io,
   output logic             mem,
   output logic             card,
   output logic             cs
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      addr = 16'hffff;
      {cs, card, mem, io} = 4'h0;
   end
   // kind bits: chip select, card access, memory cycle, io cycle
   task automatic cyc(input logic [15:0] a, input logic [3:0] k);
      @(posedge clk);
      addr <= a;
      {cs, card, mem, io} <= k;
      @(posedge clk);
      addr <= ~a;
      {cs, card, mem, io} <= 4'h0;
   endtask
endmodule

/* File: testbench/pan_activity_nmi_monitor.sv */
// Purpose: port checks for activity detection and nmi masking
// Assumes: one wait state, register written at the end of the wait state, a cycle before the data phase ends
// Notes:   mask registers are shadowed from the observed bus writes
module pan_activity_nmi_monitor
   import pan_pkg::*;
(
   input wire logic        CLK,
   input wire logic        RESETN,
   input wire logic        HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0]  HTRANS,
   input wire logic        HWRITE,
   input wire logic [31:0] HWDATA,
   input wire logic        HREADY,
   input wire logic        HREADYOUT,
   input wire logic        SYS_IO_CYCLE,
   input wire logic        CARD_CTRL_ACCESS,
   input wire logic        CHIP_SELECT_ACTIVE,
   input wire logic        OUTSIDE_EVENT_INPUT,
   input wire logic        SLEEP_TIMER_EXPIRED,
   input wire logic        PM_IN_DOZE,
   input wire logic        POWER_MANAGER_NMI,
   input wire logic        ACTIVITY_DETECTED,
   input wire logic        RESUME_REQUEST,
   input wire logic        GO_SLEEP,
   input wire logic        GO_ON,
   input wire logic        SUSPEND_COMMAND
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       take;
   logic       pend_q;
   logic [7:0] wa_q;
   logic [7:0] msk_q;
   logic [2:0] amsk_q;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);
   assign take = HSEL & HREADY & HREADYOUT & (HTRANS == HTRANS_NONSEQ);
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         pend_q <= 1'b0;
         wa_q   <= 8'h00;
      end else begin
         pend_q <= take & HWRITE & (HADDR[31:10] == 22'h0) & (HADDR[1:0] == 2'h0);
         wa_q   <= take ? HADDR[9:2] : wa_q;
      end
   end
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         msk_q  <= NMI_MASK_RST;
         amsk_q <= ACTIVITY_MASK_RST;
      end else if (pend_q && wa_q == IDX_NMI_SOURCE_MSK) begin
         msk_q  <= HWDATA[7:0] & NMI_MASK_WRITABLE;
      end else if (pend_q && wa_q == IDX_ACTIVITY_MASK) begin
         amsk_q <= HWDATA[2:0];
      end
   end
   a_suspend_by_cmd: assert property (
      SUSPEND_COMMAND |-> $past(pend_q && (wa_q == IDX_SUSPEND_CMD))) else $error("stray suspend");
   a_resume_unmasked: assert property (
      $rose(OUTSIDE_EVENT_INPUT) |=> RESUME_REQUEST) else $error("resume missing");
   a_global_blocks: assert property (
      msk_q[7] && $past(msk_q[7]) |-> !POWER_MANAGER_NMI) else $error("nmi while masked");
   a_doze_to_sleep: assert property (
      SLEEP_TIMER_EXPIRED && PM_IN_DOZE && msk_q[4] |=> GO_SLEEP) else $error("no sleep");
   a_doze_holds_nmi: assert property (
      SLEEP_TIMER_EXPIRED && PM_IN_DOZE && !msk_q[4] && !msk_q[7]
      |=> !GO_SLEEP ##1 POWER_MANAGER_NMI) else $error("doze expiry wrong");
   a_sleep_stays: assert property (
      GO_ON |-> $past(msk_q[4])) else $error("wake with sleep nmi enabled");
   a_chip_sel_act: assert property (
      CHIP_SELECT_ACTIVE && !amsk_q[0] |=> ACTIVITY_DETECTED) else $error("cs activity lost");
   a_activity_cause: assert property (
      ACTIVITY_DETECTED |-> $past(CARD_CTRL_ACCESS | SYS_IO_CYCLE | CHIP_SELECT_ACTIVE))
      else $error("activity without source");
   c_go_sleep: cover property (GO_SLEEP);
   c_nmi: cover property ($rose(POWER_MANAGER_NMI));
   c_resume: cover property (RESUME_REQUEST);
endmodule

/* File: testbench/tb.sv */
// Purpose: directed scenarios for activity masking, io window and nmi masks
// Assumes: register byte address is four times the index
// Notes:   event inputs change only right after a rising edge
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb
   import pan_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        CLK, RESETN, HSEL, HWRITE, HREADYOUT, HRESP;
   logic [31:0] HADDR, HWDATA, HRDATA, rd;
   logic [1:0]  HTRANS;
   logic [2:0]  HSIZE;
   logic [15:0] SYSTEM_ADDR_BUS;
   logic        SYS_IO_CYCLE, SYS_MEM_CYCLE, CARD_CTRL_ACCESS, CHIP_SELECT_ACTIVE;
   logic        BATTERY_WARN_A_INPUT, BATTERY_WARN_B_INPUT, OUTSIDE_EVENT_INPUT;
   logic        SLEEP_TIMER_EXPIRED, SUSPEND_TIMER_EXPIRED, PM_IN_DOZE, PM_IN_SLEEP;
   logic        POWER_MANAGER_NMI, ACTIVITY_DETECTED, RESUME_REQUEST;
   logic        GO_SLEEP, GO_ON, SUSPEND_COMMAND, seen;
   int          num_errors, total_checks, cycles, susp_cnt;
   pan_activity_nmi u_pan_activity_nmi (.CLK, .RESETN, .HSEL, .HADDR, .HTRANS, .HWRITE,
      .HSIZE, .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .SYSTEM_ADDR_BUS,
      .SYS_IO_CYCLE, .SYS_MEM_CYCLE, .CARD_CTRL_ACCESS, .CHIP_SELECT_ACTIVE,
      .BATTERY_WARN_A_INPUT, .BATTERY_WARN_B_INPUT, .OUTSIDE_EVENT_INPUT,
      .SLEEP_TIMER_EXPIRED, .SUSPEND_TIMER_EXPIRED, .PM_IN_DOZE, .PM_IN_SLEEP,
      .POWER_MANAGER_NMI, .ACTIVITY_DETECTED, .RESUME_REQUEST, .GO_SLEEP, .GO_ON,
      .SUSPEND_COMMAND);
   pan_sys_bus_model u_bus (.clk(CLK), .addr(SYSTEM_ADDR_BUS), .io(SYS_IO_CYCLE),
      .mem(SYS_MEM_CYCLE), .card(CARD_CTRL_ACCESS), .cs(CHIP_SELECT_ACTIVE));
   task automatic ahb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      @(posedge CLK);
      HSEL   <= 1'b1;
      HTRANS <= HTRANS_NONSEQ;
      HWRITE <= w;
      HADDR  <= {22'h0, idx, 2'h0};
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      HTRANS <= 2'h0;
      HWDATA <= {24'h0, d};
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      rd = HRDATA;
   endtask
   task automatic rdchk(input logic [7:0] idx, input logic [7:0] e);
      ahb(1'b0, idx, 8'h00);
      `CHK(rd, {24'h0, e})
   endtask
   task automatic w3;
      repeat (3) @(posedge CLK);
      #1;
   endtask
   task automatic tmr;
      @(posedge CLK);
      SLEEP_TIMER_EXPIRED   <= 1'b1;
      SUSPEND_TIMER_EXPIRED <= 1'b1;
      @(posedge CLK);
      SLEEP_TIMER_EXPIRED   <= 1'b0;
      SUSPEND_TIMER_EXPIRED <= 1'b0;
      #1;
   endtask
   task automatic t_reset;
      rdchk(IDX_NMI_SOURCE_MSK, 8'hbe);
      rdchk(IDX_IO_WATCH_RANGE, 8'h00);
      rdchk(IDX_ACTIVITY_MASK, 8'h00);
      ahb(1'b1, IDX_NMI_SOURCE_MSK, 8'hff);
      rdchk(IDX_NMI_SOURCE_MSK, 8'hbe);
      ahb(1'b1, 8'hd0, 8'h5a);
      rdchk(8'hd0, 8'h00);
      `CHK(HRESP, 1'b0)
      $display("t_reset done");
   endtask
   task automatic t_act;
      logic [15:0] a[3] = '{16'h0060, 16'h0300, 16'h0300};
      logic [3:0]  k[3] = '{4'b0001, 4'b0100, 4'b1000};
      logic [7:0]  m[3] = '{8'h02, 8'h04, 8'h01};
      for (int i = 0; i < 3; i++) begin
         u_bus.cyc(a[i], k[i]);
         #1;
         `CHK(ACTIVITY_DETECTED, 1'b1)
         ahb(1'b1, IDX_ACTIVITY_MASK, m[i]);
         u_bus.cyc(a[i], k[i]);
         #1;
         `CHK(ACTIVITY_DETECTED, 1'b0)
         ahb(1'b1, IDX_ACTIVITY_MASK, 8'h00);
      end
      $display("t_act done");
   endtask
   task automatic t_win;
      logic [7:0]  r[7] = '{8'hd5, 8'hd5, 8'hd5, 8'hd5, 8'h55, 8'h55, 8'h55};
      logic [15:0] a[7] = '{16'h2a8, 16'h2af, 16'h2a0, 16'h2a8, 16'h2a0, 16'h2af, 16'h2b0};
      logic [3:0]  k[7] = '{4'h1, 4'h1, 4'h1, 4'h2, 4'h1, 4'h1, 4'h1};
      logic [6:0]  e    = 7'b0110011;
      for (int i = 0; i < 7; i++) begin
         ahb(1'b1, IDX_IO_WATCH_RANGE, r[i]);
         u_bus.cyc(a[i], k[i]);
         #1;
         `CHK(ACTIVITY_DETECTED, e[i])
      end
      rdchk(IDX_IO_WATCH_RANGE, 8'h55);
      ahb(1'b1, IDX_IO_WATCH_RANGE, 8'h00);
      $display("t_win done");
   endtask
   task automatic t_nmi;
      ahb(1'b1, IDX_NMI_SOURCE_MSK, 8'h3e);
      @(posedge CLK);
      BATTERY_WARN_A_INPUT <= 1'b1;
      w3();
      `CHK(POWER_MANAGER_NMI, 1'b0)
      rdchk(IDX_NMI_PENDING, 8'h04);
      ahb(1'b1, IDX_NMI_SOURCE_MSK, 8'hba);
      w3();
      `CHK(POWER_MANAGER_NMI, 1'b0)
      ahb(1'b1, IDX_NMI_SOURCE_MSK, 8'h3a);
      w3();
      `CHK(POWER_MANAGER_NMI, 1'b1)
      ahb(1'b1, IDX_NMI_PENDING, 8'h04);
      ahb(1'b1, IDX_NMI_SOURCE_MSK, 8'h36);
      BATTERY_WARN_B_INPUT <= 1'b1;
      w3();
      `CHK(POWER_MANAGER_NMI, 1'b1)
      ahb(1'b1, IDX_NMI_PENDING, 8'h08);
      w3();
      `CHK(POWER_MANAGER_NMI, 1'b0)
      $display("t_nmi done");
   endtask
   task automatic t_out;
      ahb(1'b1, IDX_NMI_SOURCE_MSK, 8'hbe);
      OUTSIDE_EVENT_INPUT <= 1'b1;
      @(posedge CLK);
      #1;
      `CHK(RESUME_REQUEST, 1'b1)
      w3();
      `CHK(POWER_MANAGER_NMI, 1'b0)
      ahb(1'b1, IDX_NMI_PENDING, 8'h02);
      ahb(1'b1, IDX_NMI_SOURCE_MSK, 8'h3c);
      OUTSIDE_EVENT_INPUT <= 1'b0;
      @(posedge CLK);
      OUTSIDE_EVENT_INPUT <= 1'b1;
      w3();
      `CHK(POWER_MANAGER_NMI, 1'b1)
      ahb(1'b1, IDX_NMI_PENDING, 8'h02);
      ahb(1'b1, IDX_NMI_SOURCE_MSK, 8'hbe);
      $display("t_out done");
   endtask
   task automatic t_sleep;
      PM_IN_DOZE <= 1'b1;
      tmr();
      `CHK(GO_SLEEP, 1'b1)
      `CHK(SUSPEND_COMMAND, 1'b0)
      ahb(1'b1, IDX_NMI_PENDING, 8'h30);
      ahb(1'b1, IDX_NMI_SOURCE_MSK, 8'h0e);
      tmr();
      `CHK(GO_SLEEP, 1'b0)
      `CHK(SUSPEND_COMMAND, 1'b0)
      w3();
      `CHK(POWER_MANAGER_NMI, 1'b1)
      ahb(1'b1, IDX_NMI_PENDING, 8'h10);
      w3();
      `CHK(POWER_MANAGER_NMI, 1'b1)
      ahb(1'b1, IDX_NMI_SOURCE_MSK, 8'hbe);
      ahb(1'b1, IDX_SUSPEND_CMD, 8'h01);
      PM_IN_DOZE  <= 1'b0;
      PM_IN_SLEEP <= 1'b1;
      u_bus.cyc(16'h0060, 4'h1);
      seen = 1'b0;
      repeat (4) begin
         #1;
         seen = seen | GO_ON;
         @(posedge CLK);
      end
      `CHK(seen, 1'b1)
      `CHK(susp_cnt, 1)
      ahb(1'b1, IDX_NMI_PENDING, 8'h3e);
      ahb(1'b1, IDX_NMI_SOURCE_MSK, 8'h2e);
      u_bus.cyc(16'h0060, 4'h1);
      seen = 1'b0;
      repeat (4) begin
         #1;
         seen = seen | GO_ON;
         @(posedge CLK);
      end
      `CHK(seen, 1'b0)
      `CHK(POWER_MANAGER_NMI, 1'b1)
      $display("t_sleep done");
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   initial begin
      {RESETN, HSEL, HWRITE, HTRANS, HADDR, HWDATA} = '0;
      HSIZE = 3'h2;
      {BATTERY_WARN_A_INPUT, BATTERY_WARN_B_INPUT, OUTSIDE_EVENT_INPUT} = 3'h0;
      {SLEEP_TIMER_EXPIRED, SUSPEND_TIMER_EXPIRED, PM_IN_DOZE, PM_IN_SLEEP} = 4'h0;
      repeat (5) @(posedge CLK);
      RESETN <= 1'b1;
      t_reset();
      t_act();
      t_win();
      t_nmi();
      t_out();
      t_sleep();
      report_and_stop();
   end
   // a hung handshake would otherwise stall the run forever
   always @(posedge CLK) begin
      cycles++;
      if (SUSPEND_COMMAND === 1'b1) begin
         susp_cnt++;
      end
      if (cycles == 5000) begin
         num_errors++;
         report_and_stop();
      end
   end
endmodule
bind pan_activity_nmi pan_activity_nmi_monitor u_mon (.CLK, .RESETN, .HSEL, .HADDR,
   .HTRANS, .HWRITE, .HWDATA, .HREADY, .HREADYOUT, .SYS_IO_CYCLE, .CARD_CTRL_ACCESS,
   .CHIP_SELECT_ACTIVE, .OUTSIDE_EVENT_INPUT, .SLEEP_TIMER_EXPIRED, .PM_IN_DOZE,
   .POWER_MANAGER_NMI, .ACTIVITY_DETECTED, .RESUME_REQUEST, .GO_SLEEP, .GO_ON,
   .SUSPEND_COMMAND);
